// [hdl/dpsc_pkg.sv]
// Shared constants, opcodes and carrier types for the dual pot serial command decoder.
package dpsc_pkg;
  localparam int NUM_POTS = 2;
  localparam int NUM_PRESETS = 4;
  localparam int TAP_W = 6;
  localparam int BYTE_W = 8;
  localparam int TAP_SWITCHES = 64;
  localparam logic [TAP_W-1:0] TAP_MAX = 6'h3F;
  localparam logic [TAP_W-1:0] TAP_MIN = 6'h00;
  localparam logic [TAP_SWITCHES-1:0] SWITCH_RST = 64'h0000_0000_0000_0001;
  localparam logic [BYTE_W-1:0] PRESET_RST = 8'h00;
  // Serial frame positions, counted in rising serial clock edges from zero.
  localparam logic [4:0] CNT_ID_END = 5'h07;
  localparam logic [4:0] CNT_INS_END = 5'h0F;
  localparam logic [4:0] CNT_DATA_FIRST = 5'h10;
  localparam logic [4:0] CNT_DAT_END = 5'h17;
  localparam logic [4:0] CNT_MAX = 5'h1F;
  // Field positions inside the identification and instruction bytes.
  localparam int ID_TYPE_LSB = 4;
  localparam int ID_ADDR_LSB = 0;
  localparam int INS_OP_LSB = 4;
  localparam int INS_IDX_LSB = 2;
  localparam int INS_POT_BIT = 0;
  // Bit slots of the clk-domain synchroniser bank.
  localparam int SY_CS = 0;
  localparam int SY_WP = 1;
  localparam int SY_EV = 2;
  localparam int SY_INC = 3;
  localparam int SY_DEC = 4;
  localparam int SY_W = 5;
  // Timing, in nanoseconds, and derived clock counts at 50 MHz.
  localparam int CLK_PERIOD_NS = 20;
  localparam int NV_WRITE_TIME_NS = 10_000_000;
  localparam int TAP_SETTLE_DELAY_NS = 1000;
  localparam int NV_WRITE_CYC = NV_WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int TAP_SETTLE_CYC = (TAP_SETTLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NV_CNT_W = 20;
  localparam int SETTLE_CNT_W = 12;

  typedef enum logic [3:0] {
    OP_GXFR_P2T = 4'h1,
    OP_INCDEC = 4'h2,
    OP_STATUS = 4'h5,
    OP_GXFR_T2P = 4'h8,
    OP_RD_TAP = 4'h9,
    OP_WR_TAP = 4'hA,
    OP_RD_PRE = 4'hB,
    OP_WR_PRE = 4'hC,
    OP_XFR_P2T = 4'hD,
    OP_XFR_T2P = 4'hE
  } dpsc_op_e;

  typedef struct packed {
    dpsc_op_e op;
    logic [1:0] idx;
    logic pot;
    logic [BYTE_W-1:0] data;
  } dpsc_cmd_s;
endpackage : dpsc_pkg

// [hdl/dpsc_core.sv]
// Serial command decoder, tap and preset registers of a dual 64-tap potentiometer.
//
// Summary of operation
// - ID byte first, upper nibble is type code.
// - Low two ID bits must match strap pins.
// - Instruction: opcode, preset index, pot select bit.
// - Four transfers end after the instruction byte.
// - Preset-to-tap load lands after settle delay.
// - Tap-to-preset starts nonvolatile write, busy flagged.
// - Global transfers act on both pots together.
// - Reads and writes carry a third data byte.
// - Increment step per high-SI clock pulse, held at TAP_MAX.
// - Decrement step per low-SI clock pulse.
// - Tap value decoded one-hot onto 64 switches.
// - Power-up loads each tap from first preset.
// - Preset change completes within ten milliseconds.
// - Tap reads back as two zeros, six bits.
// - Read tap returns selected tap register.
// - Write tap loads data byte into tap.
// - Read preset returns selected preset byte.
// - Write preset runs a nonvolatile write cycle.
// - Write starts at chip select rise; busy meanwhile.
// - Write-protect low blocks nonvolatile writes.
// - Sample on rising, drive on falling, hi-Z deselected.
// - Status byte is seven zeros and busy flag.
`timescale 1ns/1ns
`default_nettype none
module dpsc_core import dpsc_pkg::*; #(
  parameter logic [3:0] DEV_TYPE_CODE = 4'hA, // Arbitrary value.
  parameter int NV_CYCLES = NV_WRITE_CYC,
  parameter int TAP_SETTLE = TAP_SETTLE_CYC,
  parameter logic [BYTE_W-1:0] PRESET_INIT = PRESET_RST
) (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic sck, // Serial clock from the host.
  input wire logic cs_n, // Chip select, active low.
  input wire logic si, // Serial data in.
  output logic so_out, // Serial data out value.
  output logic so_oe, // Serial data out enable.
  input wire logic [1:0] strap_address_pins, // Board strap address.
  input wire logic wp_n, // Write protect, active low.
  output logic write_busy_flag, // Nonvolatile write in progress.
  output logic [NUM_POTS-1:0][TAP_SWITCHES-1:0] tap_switch, // One-hot switch closes.
  output logic [NUM_POTS-1:0][TAP_W-1:0] tap_position_register // Current taps.
);
  localparam int SETTLE_D = TAP_SETTLE;
  // Toggle lines reset to their sources' reset level, so no false event follows reset.
  localparam logic [SY_W-1:0] SYNC_RST = SY_W'((1 << SY_CS) | (1 << SY_WP));

  // Serial clock domain.
  logic frame_rst;
  logic [4:0] bit_cnt;
  logic [BYTE_W-2:0] shift_q;
  logic [BYTE_W-1:0] in_byte;
  logic ignore;
  logic reading;
  logic [BYTE_W-1:0] out_byte;
  logic [BYTE_W-1:0] rd_byte;
  dpsc_op_e in_op;
  logic in_pot;
  logic [1:0] in_idx;
  dpsc_cmd_s cmd;
  logic ev_tgl;
  logic inc_tgl;
  logic dec_tgl;
  logic so_q;
  logic so_oe_q;
  logic [1:0] strap_m, strap_s;
  logic busy_m, busy_s;
  logic [NUM_POTS-1:0][TAP_W-1:0] tap_m, tap_s;
  logic [NUM_POTS-1:0][NUM_PRESETS-1:0][BYTE_W-1:0] pre_m, pre_s;

  // System clock domain.
  logic [SY_W-1:0] sync_m, sync_s, sync_d;
  logic ev, cs_rise, inc_ev, dec_ev;
  logic [NUM_POTS-1:0][TAP_W-1:0] tap;
  logic [NUM_POTS-1:0][NUM_PRESETS-1:0][BYTE_W-1:0] preset_register;
  logic booted;
  logic pend;
  dpsc_cmd_s pend_cmd;
  logic busy;
  logic [NV_CNT_W-1:0] nv_cnt;
  logic settle_on;
  logic [SETTLE_CNT_W-1:0] settle_cnt;
  logic [NUM_POTS-1:0] settle_mask;
  logic [NUM_POTS-1:0][TAP_W-1:0] settle_val;
  logic tap_load;
  logic commit;

  // A frame ends the moment chip select rises, so the frame state needs no serial edge to clear.
  assign frame_rst = cs_n || !rst_n;
  assign in_byte = {shift_q, si};
  assign in_op = dpsc_op_e'(in_byte[INS_OP_LSB +: 4]);
  assign in_pot = in_byte[INS_POT_BIT];
  assign in_idx = in_byte[INS_IDX_LSB +: 2];

  // Quasi-static words, stable for many serial edges, are brought over by two flip-flops.
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      strap_m <= '0;
      strap_s <= '0;
      busy_m <= 1'b0;
      busy_s <= 1'b0;
      tap_m <= '0;
      tap_s <= '0;
      pre_m <= '0;
      pre_s <= '0;
    end else begin
      strap_m <= strap_address_pins;
      strap_s <= strap_m;
      busy_m <= busy;
      busy_s <= busy_m;
      tap_m <= tap;
      tap_s <= tap_m;
      pre_m <= preset_register;
      pre_s <= pre_m;
    end
  end

  always_comb begin
    rd_byte = '0;
    case (in_op)
      OP_RD_TAP: rd_byte = {{(BYTE_W-TAP_W){1'b0}}, tap_s[in_pot]};
      OP_RD_PRE: rd_byte = pre_s[in_pot][in_idx];
      OP_STATUS: rd_byte = {{(BYTE_W-1){1'b0}}, busy_s};
      default: rd_byte = '0;
    endcase
  end

  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt <= '0;
      shift_q <= '0;
      ignore <= 1'b0;
      reading <= 1'b0;
      out_byte <= '0;
    end else begin
      if (bit_cnt != CNT_MAX) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
      shift_q <= in_byte[BYTE_W-2:0];
      if (bit_cnt == CNT_ID_END &&
          (in_byte[ID_TYPE_LSB +: 4] != DEV_TYPE_CODE ||
           in_byte[ID_ADDR_LSB +: 2] != strap_s)) begin
        ignore <= 1'b1;
      end
      if (!ignore && bit_cnt == CNT_INS_END) begin
        reading <= (in_op == OP_RD_TAP) || (in_op == OP_RD_PRE) || (in_op == OP_STATUS);
        out_byte <= rd_byte;
      end
    end
  end

  // The held command outlives the frame so the system clock side can read it after the toggle.
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= '0;
      ev_tgl <= 1'b0;
      inc_tgl <= 1'b0;
      dec_tgl <= 1'b0;
    end else if (!cs_n && !ignore) begin
      if (bit_cnt == CNT_INS_END) begin
        cmd.op <= in_op;
        cmd.idx <= in_idx;
        cmd.pot <= in_pot;
        if (in_op == OP_XFR_P2T || in_op == OP_XFR_T2P ||
            in_op == OP_GXFR_P2T || in_op == OP_GXFR_T2P) begin
          ev_tgl <= ~ev_tgl;
        end
      end
      if (bit_cnt == CNT_DAT_END && (cmd.op == OP_WR_TAP || cmd.op == OP_WR_PRE)) begin
        cmd.data <= in_byte;
        ev_tgl <= ~ev_tgl;
      end
      if (bit_cnt >= CNT_DATA_FIRST && cmd.op == OP_INCDEC) begin
        if (si) begin
          inc_tgl <= ~inc_tgl;
        end else begin
          dec_tgl <= ~dec_tgl;
        end
      end
    end
  end

  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      so_oe_q <= reading && bit_cnt >= CNT_DATA_FIRST && bit_cnt <= CNT_DAT_END;
      so_q <= out_byte[~bit_cnt[2:0]];
    end
  end

  assign so_out = so_q;
  assign so_oe = so_oe_q;

  // System clock side: the serial events arrive as toggles, one synchroniser per line.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_m <= SYNC_RST;
      sync_s <= SYNC_RST;
      sync_d <= SYNC_RST;
    end else begin
      sync_m <= {dec_tgl, inc_tgl, ev_tgl, wp_n, cs_n};
      sync_s <= sync_m;
      sync_d <= sync_s;
    end
  end

  assign ev = sync_s[SY_EV] ^ sync_d[SY_EV];
  assign inc_ev = sync_s[SY_INC] ^ sync_d[SY_INC];
  assign dec_ev = sync_s[SY_DEC] ^ sync_d[SY_DEC];
  assign cs_rise = sync_s[SY_CS] && !sync_d[SY_CS];
  assign tap_load = settle_on && settle_cnt == '0;
  assign commit = cs_rise && pend && sync_s[SY_WP] && !busy;

  // Settle timer for preset-to-tap transfers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_on <= 1'b0;
      settle_cnt <= '0;
      settle_mask <= '0;
      settle_val <= '0;
    end else if (ev && (cmd.op == OP_XFR_P2T || cmd.op == OP_GXFR_P2T)) begin
      settle_on <= 1'b1;
      settle_cnt <= SETTLE_CNT_W'(TAP_SETTLE - 1);
      for (int p = 0; p < NUM_POTS; p++) begin
        settle_val[p] <= preset_register[p][cmd.idx][TAP_W-1:0];
        settle_mask[p] <= (cmd.op == OP_GXFR_P2T) || (cmd.pot == 1'(p));
      end
    end else if (tap_load) begin
      settle_on <= 1'b0;
    end else if (settle_on) begin
      settle_cnt <= settle_cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tap <= '0;
      booted <= 1'b0;
    end else if (!booted) begin
      booted <= 1'b1;
      for (int p = 0; p < NUM_POTS; p++) begin
        tap[p] <= preset_register[p][0][TAP_W-1:0];
      end
    end else begin
      for (int p = 0; p < NUM_POTS; p++) begin
        if (tap_load && settle_mask[p]) begin
          tap[p] <= settle_val[p];
        end else if (ev && cmd.op == OP_WR_TAP && cmd.pot == 1'(p)) begin
          tap[p] <= cmd.data[TAP_W-1:0];
        end else if (cmd.pot == 1'(p) && inc_ev && !dec_ev && tap[p] != TAP_MAX) begin
          tap[p] <= tap[p] + 1'b1;
        end else if (cmd.pot == 1'(p) && dec_ev && !inc_ev && tap[p] != TAP_MIN) begin
          tap[p] <= tap[p] - 1'b1;
        end
      end
    end
  end

  assign tap_position_register = tap;

  // Pending nonvolatile write, armed by a complete write sequence.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= 1'b0;
      pend_cmd <= '0;
    end else if (ev && (cmd.op == OP_XFR_T2P || cmd.op == OP_GXFR_T2P ||
                        cmd.op == OP_WR_PRE)) begin
      pend <= 1'b1;
      pend_cmd <= cmd;
    end else if (cs_rise) begin
      pend <= 1'b0;
    end
  end

  // Presets are written at the start of the busy window; a commit while busy is dropped.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preset_register <= {(NUM_POTS*NUM_PRESETS){PRESET_INIT}};
    end else if (commit) begin
      for (int p = 0; p < NUM_POTS; p++) begin
        if (pend_cmd.op == OP_WR_PRE && pend_cmd.pot == 1'(p)) begin
          preset_register[p][pend_cmd.idx] <= pend_cmd.data;
        end else if ((pend_cmd.op == OP_XFR_T2P && pend_cmd.pot == 1'(p)) ||
                     pend_cmd.op == OP_GXFR_T2P) begin
          preset_register[p][pend_cmd.idx] <= {{(BYTE_W-TAP_W){1'b0}}, tap[p]};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      nv_cnt <= '0;
    end else if (commit) begin
      busy <= 1'b1;
      nv_cnt <= NV_CNT_W'(NV_CYCLES - 1);
    end else if (busy) begin
      if (nv_cnt == '0) begin
        busy <= 1'b0;
      end else begin
        nv_cnt <= nv_cnt - 1'b1;
      end
    end
  end

  assign write_busy_flag = busy;

  for (genvar p = 0; p < NUM_POTS; p++) begin : g_switch
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        tap_switch[p] <= SWITCH_RST;
      end else begin
        tap_switch[p] <= SWITCH_RST << tap[p];
      end
    end
  end

  // Checks.
  logic [NV_CNT_W:0] busy_age;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_age <= '0;
    end else if (busy) begin
      busy_age <= busy_age + 1'b1;
    end else begin
      busy_age <= '0;
    end
  end

  sequence settle_start_s;
    ev && cmd.op == OP_XFR_P2T;
  endsequence

  sequence settle_hold_s;
    !tap_load [*2];
  endsequence

  sequence rd_first_s;
    reading && bit_cnt == CNT_DATA_FIRST;
  endsequence

  busy_length_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(busy) |-> busy_age == (NV_CNT_W+1)'(NV_CYCLES))
    else $error("write busy window has the wrong length");

  wp_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cs_rise && !sync_s[SY_WP]) |=> $stable(preset_register) && !$rose(busy))
    else $error("write went ahead while write protect was low");

  commit_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cs_rise && pend && sync_s[SY_WP] && !busy) |=> busy && !pend)
    else $error("complete write sequence did not start busy");

  settle_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
    settle_start_s |=> settle_hold_s ##(SETTLE_D-2) tap_load)
    else $error("tap load did not follow the settle delay");

  inc_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (booted && inc_ev && !dec_ev && !tap_load && !ev && cmd.pot == 1'b0) |=>
    tap[0] == (($past(tap[0]) == TAP_MAX) ? TAP_MAX : $past(tap[0]) + 1'b1))
    else $error("increment step or ceiling wrong");

  dec_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (booted && dec_ev && !inc_ev && !tap_load && !ev && cmd.pot == 1'b1) |=>
    tap[1] == (($past(tap[1]) == TAP_MIN) ? TAP_MIN : $past(tap[1]) - 1'b1))
    else $error("decrement step or floor wrong");

  switch_onehot_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 ($onehot(tap_switch[0]) && tap_switch[1] == (SWITCH_RST << $past(tap[1]))))
    else $error("switch decode does not follow the tap");

  mismatch_quiet_a: assert property (@(negedge sck) disable iff (frame_rst)
    ignore |-> !so_oe_q && !reading)
    else $error("ignored frame still drives the serial output");

  read_drive_a: assert property (@(negedge sck) disable iff (frame_rst)
    rd_first_s |=> (so_oe_q && so_q == out_byte[BYTE_W-1]) ##7
    (so_oe_q && so_q == out_byte[0]))
    else $error("read byte not driven across its eight bits");

  status_byte_a: assert property (@(posedge sck) disable iff (frame_rst)
    (bit_cnt == CNT_INS_END && !ignore && (in_op == OP_STATUS || in_op == OP_RD_TAP)) |=>
    out_byte[BYTE_W-1:TAP_W] == '0)
    else $error("padding bits of read byte not zero");
endmodule : dpsc_core
`default_nettype wire

// [dv/dpsc_host_model.sv]
// Host serial master model that frames commands and samples the read byte.
`timescale 1ns/1ns
`default_nettype none
module dpsc_host_model (
  output logic sck, // Serial clock, still outside frames.
  output logic cs_n, // Chip select, active low.
  output logic si, // Serial data to the device.
  input wire logic so_out, // Serial data from the device.
  input wire logic so_oe // Device output enable.
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Sends b[31] first; the period is 48 ns and the read byte is taken late in the low phase.
  task automatic xfer(input logic [31:0] b, input int n, output logic [7:0] rd,
                      output logic oe_seen);
    rd = 8'h00;
    oe_seen = 1'b0;
    cs_n = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      si = b[31-i];
      #4 sck = 1'b1;
      #24 sck = 1'b0;
      #20;
      // The bit for the next rising edge stands now; a released output reads inverted.
      if (i >= 15 && i < 23) begin
        rd[22-i] = so_oe ? so_out : ~so_out;
      end
      oe_seen = oe_seen | so_oe;
    end
    // Chip select stays low long enough for the last event to cross to the system clock.
    #100 cs_n = 1'b1;
    si = ~si;
    #100;
  endtask : xfer
endmodule : dpsc_host_model
`default_nettype wire

// [dv/dpsc_core_tb_top.sv]
// Self-checking bench for the dual potentiometer serial command decoder.
`timescale 1ns/1ns
`default_nettype none
module dpsc_core_tb_top import dpsc_pkg::*; ;
  localparam logic [3:0] DEV = 4'h6; // Arbitrary type code.
  localparam logic [1:0] ADR = 2'h2;
  localparam int NV = 200;
  localparam int SET = 40;
  localparam logic [7:0] PINIT = 8'h15;
  logic clk, rst_n, sck, cs_n, si, so_out, so_oe, wp_n, busy;
  logic [1:0] strap;
  logic [NUM_POTS-1:0][TAP_SWITCHES-1:0] tsw;
  logic [NUM_POTS-1:0][TAP_W-1:0] tap;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] rd;
  logic oe;
  int busy_run = 0;
  int last_run = 0;

  dpsc_core #(.DEV_TYPE_CODE(DEV), .NV_CYCLES(NV), .TAP_SETTLE(SET), .PRESET_INIT(PINIT)) u_dut (
    .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out),
    .so_oe(so_oe), .strap_address_pins(strap), .wp_n(wp_n), .write_busy_flag(busy),
    .tap_switch(tsw), .tap_position_register(tap));
  dpsc_host_model u_host (.sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe(so_oe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("mismatch at %0t: run did not finish", $time);
      final_report();
    end
  end

  // Length of the most recent busy window, counted in system clock cycles.
  always @(posedge clk) begin
    if (busy === 1'b1) begin
      busy_run++;
    end else if (busy_run != 0) begin
      last_run = busy_run;
      busy_run = 0;
    end
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk

  task automatic cmd(input logic [3:0] op, input logic [1:0] idx, input logic pot,
                     input logic [15:0] tail, input int n);
    u_host.xfer({DEV, 2'b00, ADR, op, idx, 1'b0, pot, tail}, n, rd, oe);
    wait_clk(1);
  endtask : cmd

  task automatic set_wp(input logic v);
    @(posedge clk);
    #1 wp_n = v;
    wait_clk(4);
  endtask : set_wp

  // Waits for busy to drop, then checks the length of the whole busy window.
  task automatic nv_done();
    int hi;
    hi = 0;
    while (busy !== 1'b0 && hi < 2 * NV) begin
      wait_clk(1);
      hi++;
    end
    wait_clk(1);
    check(64'(last_run), 64'(NV), "busy length");
  endtask : nv_done

  task automatic t_powerup();
    check(tap[0], PINIT[5:0], "tap0 power-up");
    check(tap[1], PINIT[5:0], "tap1 power-up");
    check(tsw[0], 64'h1 << 21, "switch one-hot");
    $display("test powerup done");
  endtask : t_powerup

  task automatic t_tap_rw();
    cmd(4'hA, 2'h0, 1'b1, 16'h2A00, 24);
    wait_clk(10);
    check(tap[1], 6'h2A, "write tap");
    check(tsw[1], 64'h1 << 42, "switch one-hot");
    cmd(4'h9, 2'h0, 1'b1, 16'h0000, 24);
    check({oe, rd}, {1'b1, 8'h2A}, "read tap");
    $display("test tap_rw done");
  endtask : t_tap_rw

  task automatic t_preset();
    cmd(4'hC, 2'h2, 1'b0, 16'h3C00, 24);
    check(busy, 1'b1, "busy after write");
    cmd(4'h5, 2'h0, 1'b1, 16'h0000, 24);
    check({oe, rd}, {1'b1, 8'h01}, "status busy");
    nv_done();
    cmd(4'h5, 2'h0, 1'b1, 16'h0000, 24);
    check({oe, rd}, {1'b1, 8'h00}, "status idle");
    cmd(4'hB, 2'h2, 1'b0, 16'h0000, 24);
    check({oe, rd}, {1'b1, 8'h3C}, "read preset");
    $display("test preset done");
  endtask : t_preset

  task automatic t_xfer();
    cmd(4'hD, 2'h2, 1'b0, 16'h0000, 16);
    check(tap[0], PINIT[5:0], "tap before settle");
    wait_clk(SET + 10);
    check(tap[0], 6'h3C, "tap after settle");
    cmd(4'h1, 2'h0, 1'b0, 16'h0000, 16);
    wait_clk(SET + 10);
    check({tap[1], tap[0]}, {PINIT[5:0], PINIT[5:0]}, "global load");
    $display("test xfer done");
  endtask : t_xfer

  task automatic t_store();
    cmd(4'hA, 2'h0, 1'b1, 16'h0700, 24);
    set_wp(1'b0);
    cmd(4'hE, 2'h3, 1'b1, 16'h0000, 16);
    check(busy, 1'b0, "protected store");
    cmd(4'hB, 2'h3, 1'b1, 16'h0000, 24);
    check(rd, PINIT, "preset kept");
    set_wp(1'b1);
    cmd(4'hE, 2'h3, 1'b1, 16'h0000, 16);
    check(busy, 1'b1, "store busy");
    nv_done();
    cmd(4'hB, 2'h3, 1'b1, 16'h0000, 24);
    check(rd, 8'h07, "stored tap");
    cmd(4'hA, 2'h0, 1'b0, 16'h2400, 24);
    cmd(4'h8, 2'h1, 1'b0, 16'h0000, 16);
    check(busy, 1'b1, "global store busy");
    nv_done();
    cmd(4'hB, 2'h1, 1'b0, 16'h0000, 24);
    check(rd, 8'h24, "global store pot0");
    cmd(4'hB, 2'h1, 1'b1, 16'h0000, 24);
    check(rd, 8'h07, "global store pot1");
    $display("test store done");
  endtask : t_store

  task automatic t_incdec();
    cmd(4'h2, 2'h0, 1'b0, 16'hC000, 18);
    wait_clk(10);
    check(tap[0], 6'h26, "pot0 increment");
    cmd(4'hA, 2'h0, 1'b1, 16'h3E00, 24);
    cmd(4'h2, 2'h0, 1'b1, 16'hE000, 19);
    wait_clk(10);
    check(tap[1], 6'h3F, "increment stops");
    cmd(4'h2, 2'h0, 1'b1, 16'h4000, 19);
    wait_clk(10);
    check(tap[1], 6'h3E, "mixed steps");
    cmd(4'hA, 2'h0, 1'b1, 16'h0100, 24);
    cmd(4'h2, 2'h0, 1'b1, 16'h0000, 19);
    wait_clk(10);
    check(tap[1], 6'h00, "decrement stops");
    $display("test incdec done");
  endtask : t_incdec

  task automatic t_refuse();
    u_host.xfer({DEV, 2'b00, ~ADR, 4'h9, 4'h1, 16'h0000}, 24, rd, oe);
    check(oe, 1'b0, "wrong strap");
    u_host.xfer({~DEV, 2'b00, ADR, 4'h9, 4'h1, 16'h0000}, 24, rd, oe);
    check(oe, 1'b0, "wrong type");
    u_host.xfer({DEV, 2'b00, ~ADR, 4'hA, 4'h1, 16'h3300}, 24, rd, oe);
    wait_clk(10);
    check(tap[1], 6'h00, "ignored write");
    $display("test refuse done");
  endtask : t_refuse

  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    strap = ADR;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    wait_clk(10);
    t_powerup();
    t_tap_rw();
    t_preset();
    t_xfer();
    t_store();
    t_incdec();
    t_refuse();
    final_report();
  end
endmodule : dpsc_core_tb_top
`default_nettype wire
